// ---- pkg/rx_sys_port_cfg.svh ----
// Constants for the receive system port: timing, sizes and reset values
`ifndef RX_SYS_PORT_CFG_SVH
`define RX_SYS_PORT_CFG_SVH

// Link clock ceiling, and the core clock the write handshake runs on
`define RX_LINK_CLK_MAX_MHZ   52
`define RX_REF_CLK_MHZ        100

// Buffer shape: words per port, and number of ports behind the bus
`define RX_BUF_DEPTH          16
`define RX_NUM_PORTS          4

// Bus field layout: data word, end-of-unit flag above it, 8-bit lane
`define RX_DATA_W             16
`define RX_EOP_BIT            16
`define RX_LANE8_W            8
`define RX_SEL_W              5

// Reset values
`define RX_DATA_RST           16'h0000
`define RX_PAR_RST            1'h0
`define RX_EN_N_RST           1'h1
`define RX_SEL_RST            5'h00

`endif

// ---- pkg/rx_sys_port_pkg.sv ----
// Types shared by the receive system port
package rx_sys_port_pkg;

    // Bus operating mode, one-hot
    typedef enum logic [2:0]
    {
        MODE_CELL = 3'b001,
        MODE_PKT2 = 3'b010,
        MODE_PKT3 = 3'b100
    } mode_type;

    // Core-side write handshake state, one-hot
    typedef enum logic [1:0]
    {
        WR_IDLE = 2'b01,
        WR_BUSY = 2'b10
    } wr_state_type;

endpackage

// ---- src/rx_cell_packet_system_port.sv ----
// Receive system port: per-port word buffers drained onto the link data bus
`timescale 1ns/100ps
`default_nettype none
`include "rx_sys_port_cfg.svh"
// What this block does
// R1 - Every link signal is sampled or updated on the link clock, up to 52 MHz.
// R2 - Data leaves on a 16-bit bus, changed on the rising link clock edge.
// R3 - 16-bit mode uses bits 15..0; 8-bit mode uses 7..0, upper byte low.
// R4 - Parity over the data bus is updated on the same edge as the data.
// R5 - Far end selects a port with a 5-bit address, sampled on the link clock.
// R6 - In packet level-3 mode the port address is ignored.
// R7 - Enable low requests a transfer, high suppresses it; sampled on the link clock.
// R8 - Ports 2 to 4 each drive a direct available output, link-clock timed.
// R9 - Cell mode: rise above almost-empty cell count, fall when no cell ready.
// R10 - Level-2: rise above almost-empty or end ready; fall when neither holds.
// R11 - Level-3 mode holds all direct available outputs low.
// R12 - Enable high leaves read pointer and data and parity untouched.
module rx_cell_packet_system_port #(
    parameter int DEPTH = `RX_BUF_DEPTH,
    localparam int AW   = $clog2(DEPTH),
    localparam int PW   = $clog2(`RX_NUM_PORTS)
) (
    input  wire logic                      ref_clk,             // Core clock
    input  wire logic                      rst,                 // Async reset, high
    input  wire rx_sys_port_pkg::mode_type mode,                // Bus mode, static
    input  wire logic                      bus_8bit,            // 1: 8-bit bus
    input  wire logic                      parity_odd,          // 1: odd parity
    input  wire logic [AW:0]               almost_empty,        // Almost-empty level
    input  wire logic                      wr_valid,            // Word offered
    output logic                           wr_ready,            // Word taken
    input  wire logic [`RX_DATA_W-1:0]     wr_data,             // Word to buffer
    input  wire logic                      wr_eop,              // Last word of unit
    input  wire logic [PW-1:0]             wr_port,             // Target port
    input  wire logic                      rx_sys_clock,        // Link clock
    input  wire logic [`RX_SEL_W-1:0]      rx_sys_port_select,  // Port address
    input  wire logic                      rx_sys_enable_n,     // Transfer enable
    output logic [`RX_DATA_W-1:0]          rx_sys_data_bus,     // Data bus
    output logic                           rx_sys_parity,       // Bus parity
    output logic [4:2]                     rx_direct_available  // Ports 2..4 ready
);

    localparam int NP = `RX_NUM_PORTS;
    localparam logic [AW:0] CNT_ONE  = (AW+1)'(1);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

    // Parity of a data word; odd parity makes the total count of ones odd
    function automatic logic bus_parity(input logic [`RX_DATA_W-1:0] d, input logic odd);
        bus_parity = (^d) ^ odd;
    endfunction

    // Next value of a port's direct available flag
    function automatic logic avail_next(
        input rx_sys_port_pkg::mode_type m,
        input logic                      cur,
        input logic [AW:0]               words,
        input logic [AW:0]               ends,
        input logic [AW:0]               level
    );
        avail_next = 1'b0;
        unique case (m)
            rx_sys_port_pkg::MODE_CELL:
            begin
                if (ends > level)
                    avail_next = 1'b1;                         // R9
                else if (ends != '0)
                    avail_next = cur;                          // R9
            end
            rx_sys_port_pkg::MODE_PKT2:
                avail_next = (words > level) || (ends != '0);  // R10
            rx_sys_port_pkg::MODE_PKT3: avail_next = 1'b0;     // R11
            default:                    avail_next = 1'b0;
        endcase
    endfunction

    // Core side: hold a word stable while a toggle carries it across
    rx_sys_port_pkg::wr_state_type state_q;
    logic                          req_q;
    logic                          ack_s1_q;
    logic                          ack_s2_q;
    logic                          ack_q;        // Link-side echo of the request toggle
    logic [`RX_DATA_W-1:0]         hold_data_q;
    logic                          hold_eop_q;
    logic [PW-1:0]                 hold_port_q;
    assign wr_ready = state_q[0];                // Idle state bit is the ready flop

    // Write handshake; a new word waits until the link side has echoed the toggle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state_q <= rx_sys_port_pkg::WR_IDLE;
        else
        begin
            unique case (state_q)
                rx_sys_port_pkg::WR_IDLE:
                    if (wr_valid)
                        state_q <= rx_sys_port_pkg::WR_BUSY;
                rx_sys_port_pkg::WR_BUSY:
                    if (ack_s2_q == req_q)
                        state_q <= rx_sys_port_pkg::WR_IDLE;
            endcase
        end
    end

    // Request toggle and the word it carries
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            req_q       <= 1'b0;
            hold_data_q <= `RX_DATA_RST;
            hold_eop_q  <= 1'b0;
            hold_port_q <= '0;
        end
        else if (state_q == rx_sys_port_pkg::WR_IDLE && wr_valid)
        begin
            req_q       <= ~req_q;
            hold_data_q <= wr_data;
            hold_eop_q  <= wr_eop;
            hold_port_q <= wr_port;
        end
    end

    // Acknowledge toggle back from the link domain
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end
        else
        begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // Link side reset: asserted at once, released on the link clock
    logic lrst_s1_q;
    logic lrst_q;
    always_ff @(posedge rx_sys_clock or posedge rst)
    begin
        if (rst)
        begin
            lrst_s1_q <= 1'b1;
            lrst_q    <= 1'b1;
        end
        else
        begin
            lrst_s1_q <= 1'b0;
            lrst_q    <= lrst_s1_q;
        end
    end

    // Configuration levels; they must only change while the bus is idle
    rx_sys_port_pkg::mode_type mode_s1_q;
    rx_sys_port_pkg::mode_type mode_l_q;
    logic                      w8_s1_q;
    logic                      w8_l_q;
    logic                      odd_s1_q;
    logic                      odd_l_q;
    logic [AW:0]               ae_s1_q;
    logic [AW:0]               ae_l_q;
    always_ff @(posedge rx_sys_clock or posedge lrst_q)
    begin
        if (lrst_q)
        begin
            mode_s1_q <= rx_sys_port_pkg::MODE_CELL;
            mode_l_q  <= rx_sys_port_pkg::MODE_CELL;
            w8_s1_q   <= 1'b0;
            w8_l_q    <= 1'b0;
            odd_s1_q  <= 1'b0;
            odd_l_q   <= 1'b0;
            ae_s1_q   <= '0;
            ae_l_q    <= '0;
        end
        else
        begin
            mode_s1_q <= mode;
            mode_l_q  <= mode_s1_q;
            w8_s1_q   <= bus_8bit;
            w8_l_q    <= w8_s1_q;
            odd_s1_q  <= parity_odd;
            odd_l_q   <= odd_s1_q;
            ae_s1_q   <= almost_empty;
            ae_l_q    <= ae_s1_q;
        end
    end

    // Request toggle into the link domain; third stage only marks the change
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    always_ff @(posedge rx_sys_clock or posedge lrst_q)
    begin
        if (lrst_q)
        begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            ack_q    <= 1'b0;
        end
        else
        begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            ack_q    <= req_s2_q;
        end
    end

    // Far-end inputs share the link clock, so one register samples them
    logic [`RX_SEL_W-1:0] sel_q;
    logic                 en_n_q;
    always_ff @(posedge rx_sys_clock or posedge lrst_q)
    begin
        if (lrst_q)
        begin
            sel_q  <= `RX_SEL_RST;
            en_n_q <= `RX_EN_N_RST;
        end
        else
        begin
            sel_q  <= rx_sys_port_select;                       // R5
            en_n_q <= rx_sys_enable_n;                          // R7
        end
    end

    // Per-port buffers, pointers and counts of words and of unit ends
    logic [`RX_DATA_W:0] mem_q [NP][DEPTH];
    logic [AW-1:0]       wp_q [NP];
    logic [AW-1:0]       rp_q [NP];
    logic [AW:0]         cnt_q [NP];
    logic [AW:0]         ends_q [NP];
    logic [NP-1:0]       avail_q;
    logic [NP-1:0]       win;
    logic [NP-1:0]       rin;
    logic [PW-1:0]       rd_port;
    logic                rd_ok;
    logic                rd_go;
    logic                wr_go;
    logic [`RX_DATA_W:0] head;
    logic [`RX_DATA_W-1:0] out_word;
    // Read decode; level-3 has no address so port 1 is always drained
    always_comb
    begin
        rd_port = sel_q[PW-1:0];
        rd_ok   = sel_q < `RX_SEL_W'(NP);
        if (mode_l_q == rx_sys_port_pkg::MODE_PKT3)
        begin
            rd_port = '0;                                       // R6
            rd_ok   = 1'b1;                                     // R6
        end
        head  = mem_q[rd_port][rp_q[rd_port]];
        rd_go = !en_n_q && rd_ok && cnt_q[rd_port] != '0;      // R7 R12
        wr_go = (req_s2_q ^ req_s3_q) && cnt_q[hold_port_q] != CNT_FULL;
        for (int p = 0; p < NP; p++)
        begin
            win[p] = wr_go && hold_port_q == PW'(p);
            rin[p] = rd_go && rd_port == PW'(p);
        end
        if (w8_l_q)
            out_word = {{(`RX_DATA_W-`RX_LANE8_W){1'b0}}, head[`RX_LANE8_W-1:0]}; // R3
        else
            out_word = head[`RX_DATA_W-1:0];                    // R3
    end

    // Buffer storage; the word is stable in the hold register during the write
    always_ff @(posedge rx_sys_clock)
    begin
        if (wr_go)
            mem_q[hold_port_q][wp_q[hold_port_q]] <= {hold_eop_q, hold_data_q};
    end

    // Pointers and counts; a full port drops the word rather than stall the core-side writer
    always_ff @(posedge rx_sys_clock or posedge lrst_q)
    begin
        if (lrst_q)
        begin
            for (int p = 0; p < NP; p++)
            begin
                wp_q[p]   <= '0;
                rp_q[p]   <= '0;
                cnt_q[p]  <= '0;
                ends_q[p] <= '0;
            end
        end
        else
        begin
            for (int p = 0; p < NP; p++)
            begin
                if (win[p])
                    wp_q[p] <= wp_q[p] + AW'(1);
                if (rin[p])
                    rp_q[p] <= rp_q[p] + AW'(1);                // R12
                if (win[p] && !rin[p])
                    cnt_q[p] <= cnt_q[p] + CNT_ONE;
                else if (rin[p] && !win[p])
                    cnt_q[p] <= cnt_q[p] - CNT_ONE;
                if ((win[p] && hold_eop_q) && !(rin[p] && head[`RX_EOP_BIT]))
                    ends_q[p] <= ends_q[p] + CNT_ONE;
                else if ((rin[p] && head[`RX_EOP_BIT]) && !(win[p] && hold_eop_q))
                    ends_q[p] <= ends_q[p] - CNT_ONE;
            end
        end
    end

    // Data and parity change together, and only on a granted transfer
    always_ff @(posedge rx_sys_clock or posedge lrst_q)
    begin
        if (lrst_q)
        begin
            rx_sys_data_bus <= `RX_DATA_RST;
            rx_sys_parity   <= `RX_PAR_RST;
        end
        else if (rd_go)
        begin
            rx_sys_data_bus <= out_word;                        // R1 R2 R3
            rx_sys_parity   <= bus_parity(out_word, odd_l_q);   // R4
        end
    end

    // Direct available flags from counts as they stand this cycle
    always_ff @(posedge rx_sys_clock or posedge lrst_q)
    begin
        if (lrst_q)
            avail_q <= '0;
        else
        begin
            for (int p = 0; p < NP; p++)
                avail_q[p] <= avail_next(mode_l_q, avail_q[p], cnt_q[p], ends_q[p], ae_l_q); // R8
        end
    end

    // Port 1 has no direct pin here; ports 2 to 4 are buffer indices 1 to 3
    assign rx_direct_available = avail_q[3:1];                  // R8

endmodule
`default_nettype wire

// ---- test/link_layer_model.sv ----
// Link-layer device model: makes the link clock and pulls words off the bus
`timescale 1ns/100ps
`default_nettype none
module link_layer_model (
    output logic             rx_sys_clock,        // Free-running link clock
    output logic [4:0]       rx_sys_port_select,  // Port address
    output logic             rx_sys_enable_n,     // Low requests a word
    input  wire logic [15:0] rx_sys_data_bus,     // Data bus
    input  wire logic        rx_sys_parity        // Bus parity
);
    logic [16:0] got[$];  // Captured {parity, data}, oldest first

    // 12 ns clock, offset so its edges never line up with the core clock
    initial
    begin
        rx_sys_clock = 1'b0;
        rx_sys_port_select = 5'h1f;
        rx_sys_enable_n = 1'b1;
        #3.7;
        forever #6 rx_sys_clock = ~rx_sys_clock;
    end

    // Enable low for n edges on one address; each word shows two edges after its request
    task automatic pull(input logic [4:0] sel, input int n);
        int i;
        for (i = 0; i < n + 2; i++)
        begin
            @(posedge rx_sys_clock);
            #1;
            if (i >= 2)
                got.push_back({rx_sys_parity, rx_sys_data_bus});
            rx_sys_enable_n = (i >= n);
            rx_sys_port_select = (i >= n) ? 5'h1f : sel;
        end
    endtask
endmodule
`default_nettype wire

// ---- test/rx_cell_packet_system_port_sva.sv ----
// Pin-level checks on the receive system port, bound to the design top
`timescale 1ns/100ps
`default_nettype none
module rx_port_checker (
    input wire logic                      rx_sys_clock,        // Link clock
    input wire logic                      rst,                 // Async reset
    input wire rx_sys_port_pkg::mode_type mode,                // Bus mode
    input wire logic                      bus_8bit,            // 8-bit bus
    input wire logic                      parity_odd,          // Odd parity
    input wire logic                      rx_sys_enable_n,     // Transfer enable
    input wire logic [15:0]               rx_sys_data_bus,     // Data bus
    input wire logic                      rx_sys_parity,       // Bus parity
    input wire logic [4:2]                rx_direct_available  // Ports 2..4
);
    logic [19:0] mid_q;  // Outputs seen at the falling edge

    // A pin that differs at the next rising edge moved between the edges, not on one
    always_ff @(negedge rx_sys_clock or posedge rst)
    begin
        if (rst)
            mid_q <= 20'h0;
        else
            mid_q <= {rx_direct_available, rx_sys_parity, rx_sys_data_bus};
    end

    default clocking @(posedge rx_sys_clock); endclocking
    default disable iff (rst);

    // No reads can happen while enable stays high, so no count can shrink
    sequence idle_s;
        rx_sys_enable_n [*6];
    endsequence

    data_edge_a: assert property (rx_sys_data_bus == mid_q[15:0])
        else $error("Data bus moved away from the rising link edge");
    par_edge_a: assert property (rx_sys_parity == mid_q[16])
        else $error("Parity moved away from the rising link edge");
    avail_edge_a: assert property (rx_direct_available == mid_q[19:17])
        else $error("Available flags moved away from the rising link edge");
    upper_zero_a: assert property (bus_8bit |-> rx_sys_data_bus[15:8] == 8'h00)
        else $error("Upper byte driven in 8-bit mode");
    parity_a: assert property (!$stable(rx_sys_data_bus) |-> rx_sys_parity == (^rx_sys_data_bus ^ parity_odd))
        else $error("Parity does not match the new data word");
    hold_a: assert property ($past(rx_sys_enable_n, 2) |-> $stable(rx_sys_data_bus) && $stable(rx_sys_parity))
        else $error("Bus changed without a granted transfer");
    pkt3_low_a: assert property (mode == rx_sys_port_pkg::MODE_PKT3 |-> rx_direct_available == 3'h0)
        else $error("Available flag high in level-3 mode");
    no_fall_a: assert property (idle_s |=> ($past(rx_direct_available) & ~rx_direct_available) == 3'h0)
        else $error("Available flag fell with no read");
endmodule

bind rx_cell_packet_system_port rx_port_checker chk (
    .rx_sys_clock, .rst, .mode, .bus_8bit, .parity_odd, .rx_sys_enable_n,
    .rx_sys_data_bus, .rx_sys_parity, .rx_direct_available
);
`default_nettype wire

// ---- test/rx_cell_packet_system_port_test.sv ----
// Self-checking bench for the receive system port
`timescale 1ns/100ps
`default_nettype none
module rx_cell_packet_system_port_test;
    logic                      ref_clk;              // Core clock
    logic                      rst;                  // Async reset
    rx_sys_port_pkg::mode_type mode;                 // Bus mode
    logic                      bus_8bit;             // 8-bit bus
    logic                      parity_odd;           // Odd parity
    logic [4:0]                almost_empty;         // Almost-empty level
    logic                      wr_valid;             // Word offered
    logic                      wr_ready;             // Word taken
    logic [15:0]               wr_data;              // Word
    logic                      wr_eop;               // Last word of unit
    logic [1:0]                wr_port;              // Target port
    logic                      rx_sys_clock;         // Link clock
    logic [4:0]                rx_sys_port_select;   // Port address
    logic                      rx_sys_enable_n;      // Transfer enable
    logic [15:0]               rx_sys_data_bus;      // Data bus
    logic                      rx_sys_parity;        // Bus parity
    logic [4:2]                rx_direct_available;  // Ports 2..4
    int                        n_fail;               // Mismatches
    int                        tests_run;            // Comparisons

    rx_cell_packet_system_port uut (
        .ref_clk, .rst, .mode, .bus_8bit, .parity_odd, .almost_empty, .wr_valid, .wr_ready, .wr_data,
        .wr_eop, .wr_port, .rx_sys_clock, .rx_sys_port_select, .rx_sys_enable_n, .rx_sys_data_bus,
        .rx_sys_parity, .rx_direct_available
    );
    link_layer_model far (.rx_sys_clock, .rx_sys_port_select, .rx_sys_enable_n, .rx_sys_data_bus, .rx_sys_parity);

    // 100 MHz core clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Expected {parity, bus} for a buffered word under the present config
    function automatic logic [16:0] word(input logic [15:0] w);
        logic [15:0] d;
        d = bus_8bit ? {8'h00, w[7:0]} : w;
        return {^d ^ parity_odd, d};
    endfunction

    // Config only changes under reset, since the design treats it as static
    task automatic restart(input rx_sys_port_pkg::mode_type m, input logic b8, input logic odd, input logic [4:0] ae);
        @(posedge ref_clk);
        #1;
        rst = 1'b1;
        mode = m;
        bus_8bit = b8;
        parity_odd = odd;
        almost_empty = ae;
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (8) @(posedge rx_sys_clock);
    endtask

    // Offer one word and hold it until the ready edge takes it
    task automatic put(input logic [1:0] port, input logic [15:0] data, input logic eop);
        int i;
        @(posedge ref_clk);
        #1;
        wr_valid = 1'b1;
        wr_data = data;
        wr_eop = eop;
        wr_port = port;
        for (i = 0; wr_ready !== 1'b1; i++)
        begin
            if (i > 200)
            begin
                n_fail++;
                $display("FAIL %0t write never taken", $time);
                end_sim();
            end
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        #1;
        wr_valid = 1'b0;
    endtask

    // Long enough for a write to cross domains and the flags to follow
    task automatic avail_is(input logic [4:2] exp);
        repeat (12) @(posedge rx_sys_clock);
        #1;
        check({14'h0, rx_direct_available}, {14'h0, exp});
    endtask

    task automatic take(input logic [4:0] a, input logic [15:0] w[$]);
        far.got.delete();
        far.pull(a, w.size());
        foreach (w[i])
            check(far.got[i], word(w[i]));
    endtask

    task automatic cell_mode();
        restart(rx_sys_port_pkg::MODE_CELL, 1'b0, 1'b0, 5'h01);
        put(2'h1, 16'ha5c3, 1'b0);
        put(2'h1, 16'h0001, 1'b1);
        put(2'h3, 16'hffff, 1'b1);
        put(2'h3, 16'h8000, 1'b1);
        avail_is(3'b100);
        put(2'h1, 16'h7e11, 1'b1);
        avail_is(3'b101);
        take(5'h01, '{16'ha5c3, 16'h0001, 16'h7e11});
        avail_is(3'b100);
        take(5'h03, '{16'hffff, 16'h8000});
        avail_is(3'b000);
        far.got.delete();
        far.pull(5'h03, 2);
        check(far.got[1], word(16'h8000));
    endtask

    task automatic pkt2_mode();
        restart(rx_sys_port_pkg::MODE_PKT2, 1'b1, 1'b1, 5'h04);
        repeat (4) put(2'h3, 16'h00f0, 1'b0);
        avail_is(3'b000);
        put(2'h3, 16'h00f0, 1'b0);
        avail_is(3'b100);
        put(2'h2, 16'h12ab, 1'b0);
        put(2'h2, 16'h34cd, 1'b1);
        avail_is(3'b110);
        take(5'h02, '{16'h12ab, 16'h34cd});
        avail_is(3'b100);
    endtask

    task automatic pkt3_mode();
        restart(rx_sys_port_pkg::MODE_PKT3, 1'b0, 1'b0, 5'h00);
        put(2'h0, 16'hbeef, 1'b1);
        put(2'h1, 16'hcafe, 1'b1);
        avail_is(3'b000);
        check({rx_sys_parity, rx_sys_data_bus}, 17'h00000);
        take(5'h1f, '{16'hbeef});
    endtask

    initial
    begin
        rst = 1'b1;
        n_fail = 0;
        tests_run = 0;
        wr_valid = 1'b0;
        wr_data = 16'h0000;
        wr_eop = 1'b0;
        wr_port = 2'h0;
        cell_mode();
        pkt2_mode();
        pkt3_mode();
        end_sim();
    end
endmodule
`default_nettype wire
